/* e1_tx_system_backplane_port.sv */
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module e1_tx_system_backplane_port
	import e1_tx_port_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [REG_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [REG_DATA_W-1:0] reg_rdata,
	// Common backplane pins
	input wire logic common_tx_clock_a,
	input wire logic common_tx_clock_b,
	input wire logic common_tx_frame_pulse,
	// Per-framer pins
	input wire logic framer_tx_serial_in,
	input wire logic framer_signaling_in,
	output logic framer_frame_pulse_out,
	output logic framer_frame_pulse_oe,
	input wire logic line_processed_clock,
	// Multiplexed bus pins
	input wire logic mux_common_clock_b,
	input wire logic mux_frame_pulse,
	input wire logic [1:0] mux_serial_in,
	input wire logic [1:0] mux_signaling_in,
	// Jitter attenuator references
	output logic dpll_ref_a,
	output logic dpll_ref_b,
	// Time slot stream
	output logic slot_valid,
	input wire logic slot_ready,
	output logic [SLOT_W-1:0] slot_number,
	output logic [BYTE_W-1:0] slot_byte
);

	localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;

	typedef struct packed {
		logic [REG_DATA_W-1:0] cfg;
		logic [6:0] slot_offset;
		logic [REG_DATA_W-1:0] rdata;
		logic overrun;
		logic aligned;
		logic frame_pend;
		logic fp_prev;
		logic phase;
		logic [2:0] bit_cnt;
		logic [6:0] pos;
		logic [BYTE_W-1:0] data_sr;
		logic [BYTE_W-1:0] sig_sr;
		logic fs_out;
		logic fs_oe;
		logic push_valid;
		logic [WORD_W-1:0] push_word;
		logic out_valid;
		logic [WORD_W-1:0] out_word;
		logic ref_a;
		logic ref_b;
	} port_state_type;

	port_state_type state_reg;
	port_state_type state_next;
	logic [1:0] rst_pipe_reg;
	logic rst_sync_n;
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_level;
	logic [PIN_COUNT-1:0] pin_rise;
	logic [PIN_COUNT-1:0] pin_fall;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [WORD_W-1:0] fifo_out_data;
	logic [LEVEL_W-1:0] fifo_level;

	generate
		if (FIFO_DEPTH < 2 || LEVEL_W > 8) begin : g_bad_depth
			$error("FIFO_DEPTH must lie between 2 and 128.");
		end
	endgenerate

	// ----------
	// Helpers
	// ----------
	function automatic mode_type decode_mode(input logic [REG_DATA_W-1:0] cfg);
		logic [1:0] rate;
		rate = cfg[CFG_RATE_LSB +: 2];
		if (rate == RATE_MUX && cfg[CFG_SLAVE] && cfg[CFG_SIG_EN]) begin // R1
			decode_mode = MODE_MUX;
		end else if (rate == RATE_E1 && !cfg[CFG_SLAVE]) begin // R1
			decode_mode = MODE_MASTER;
		end else if (rate == RATE_E1) begin // R1
			decode_mode = cfg[CFG_SIG_EN] ? MODE_SLAVE_SIG : MODE_SLAVE_FS;
		end else begin
			decode_mode = MODE_IDLE;
		end
	endfunction

	// A select of one means the rising edge, zero the falling edge.
	function automatic logic edge_pick(input logic rise, input logic fall, input logic sel);
		edge_pick = sel ? rise : fall;
	endfunction

	function automatic logic [2:0] mode_code(input mode_type mode);
		unique case (mode)
			MODE_IDLE: mode_code = MODE_CODE_IDLE;
			MODE_SLAVE_FS: mode_code = MODE_CODE_SLAVE_FS;
			MODE_SLAVE_SIG: mode_code = MODE_CODE_SLAVE_SIG;
			MODE_MASTER: mode_code = MODE_CODE_MASTER;
			MODE_MUX: mode_code = MODE_CODE_MUX;
		endcase
	endfunction

	// ----------
	// Reset release and pin synchronisers
	// ----------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_reg[1];

	always_comb begin
		pin_raw = '0;
		pin_raw[PIN_CLKB] = common_tx_clock_b;
		pin_raw[PIN_LTCK] = line_processed_clock;
		pin_raw[PIN_MCLKB] = mux_common_clock_b;
		pin_raw[PIN_CLKA] = common_tx_clock_a;
		pin_raw[PIN_CFS] = common_tx_frame_pulse;
		pin_raw[PIN_SD] = framer_tx_serial_in;
		pin_raw[PIN_SIG] = framer_signaling_in;
		pin_raw[PIN_MFS] = mux_frame_pulse;
		pin_raw[PIN_MSD0] = mux_serial_in[0];
		pin_raw[PIN_MSD1] = mux_serial_in[1];
		pin_raw[PIN_MSIG0] = mux_signaling_in[0];
		pin_raw[PIN_MSIG1] = mux_signaling_in[1];
	end

	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_pin_sync (
		.clk(core_clk),
		.rst_n(rst_sync_n),
		.pin_in(pin_raw),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// ----------
	// Slot buffer
	// ----------
	// The backplane cannot be stalled, so a full buffer drops the byte and flags it.
	slot_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_slot_fifo (
		.clk(core_clk),
		.rst_n(rst_sync_n),
		.in_valid(state_reg.push_valid),
		.in_ready(fifo_in_ready),
		.in_data(state_reg.push_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	assign fifo_pop = fifo_out_valid && (!state_reg.out_valid || slot_ready);

	// ----------
	// Next state
	// ----------
	always_comb begin
		mode_type mode;
		logic clk_rise;
		logic clk_fall;
		logic de_evt;
		logic fe_evt;
		logic pe_evt;
		logic ser_bit;
		logic sig_bit;
		logic fp_active;
		logic frame_hit;
		logic start;
		logic ph;
		logic take;
		logic [2:0] bit_now;
		logic [6:0] pos_now;
		logic [6:0] rel;
		logic own;
		logic [SLOT_W-1:0] slot;
		logic [BYTE_W-1:0] byte_done;
		logic [BYTE_W-1:0] sig_done;
		logic [REG_DATA_W-1:0] status;
		mode = decode_mode(state_reg.cfg);
		clk_rise = 1'b0;
		clk_fall = 1'b0;
		ser_bit = pin_level[PIN_SD];
		sig_bit = pin_level[PIN_SIG]; // R9
		fp_active = pin_level[PIN_CFS] ^ state_reg.cfg[CFG_FRAME_PULSE_INVERT]; // R3
		state_next = state_reg;

		unique case (mode)
			MODE_SLAVE_FS, MODE_SLAVE_SIG: begin
				clk_rise = pin_rise[PIN_CLKB]; // R4
				clk_fall = pin_fall[PIN_CLKB];
			end
			MODE_MASTER: begin
				clk_rise = pin_rise[PIN_LTCK]; // R14
				clk_fall = pin_fall[PIN_LTCK];
			end
			MODE_MUX: begin
				clk_rise = pin_rise[PIN_MCLKB]; // R18
				clk_fall = pin_fall[PIN_MCLKB];
				ser_bit = state_reg.cfg[CFG_BUS_SEL] ? pin_level[PIN_MSD1] : pin_level[PIN_MSD0]; // R15
				sig_bit = state_reg.cfg[CFG_BUS_SEL] ? pin_level[PIN_MSIG1] : pin_level[PIN_MSIG0];
				fp_active = pin_level[PIN_MFS] ^ state_reg.cfg[CFG_FRAME_PULSE_INVERT];
			end
			MODE_IDLE: begin
			end
		endcase

		de_evt = edge_pick(clk_rise, clk_fall, state_reg.cfg[CFG_DE]); // R4
		fe_evt = edge_pick(clk_rise, clk_fall, state_reg.cfg[CFG_FE]); // R4
		pe_evt = edge_pick(clk_rise, clk_fall, state_reg.cfg[CFG_PE]); // R4

		// Frame pulse: only its leading active sample realigns, so a wide pulse is harmless.
		// A multiframe pulse simply realigns less often.
		frame_hit = 1'b0;
		if (fe_evt && mode != MODE_MASTER && mode != MODE_IDLE) begin
			state_next.fp_prev = fp_active;
			frame_hit = fp_active && !state_reg.fp_prev; // R3
		end

		// An earlier frame edge is held until the following data edge starts bit 1.
		start = de_evt && (state_reg.frame_pend || frame_hit); // R5
		if (frame_hit && !de_evt) begin
			state_next.frame_pend = 1'b1; // R5
		end else if (start) begin
			state_next.frame_pend = 1'b0;
		end

		// At twice the rate only the edge chosen by the offset bit samples a bit.
		ph = start ? 1'b0 : state_reg.phase;
		take = !state_reg.cfg[CFG_CMS] || (ph == state_reg.cfg[CFG_EDGE_OFFSET_SEL]); // R2
		bit_now = start ? 3'h0 : state_reg.bit_cnt;
		pos_now = start ? 7'h00 : state_reg.pos;
		rel = pos_now - state_reg.slot_offset; // R16
		own = (mode != MODE_MUX) || (rel[1:0] == 2'h0); // R16
		slot = (mode == MODE_MUX) ? rel[6:2] : pos_now[4:0];
		byte_done = {state_reg.data_sr[6:0], ser_bit};
		sig_done = {state_reg.sig_sr[6:0], sig_bit};
		state_next.push_valid = 1'b0;

		if (start) begin
			state_next.aligned = 1'b1;
		end
		if (mode == MODE_MASTER) begin
			state_next.aligned = 1'b1; // R13
		end else if (mode == MODE_IDLE) begin
			state_next.aligned = 1'b0;
			state_next.frame_pend = 1'b0;
		end

		if (de_evt && (state_reg.aligned || start)) begin
			state_next.phase = state_reg.cfg[CFG_CMS] ? ~ph : 1'b0; // R2
			if (take) begin
				state_next.data_sr = byte_done; // R7
				state_next.sig_sr = sig_done; // R9
				state_next.bit_cnt = bit_now + 3'h1;
				state_next.pos = pos_now;
				if (bit_now == LAST_BIT) begin
					if (mode == MODE_MUX) begin
						state_next.pos = (pos_now == LAST_MUX_BYTE) ? 7'h00 : pos_now + 7'h01;
					end else begin
						state_next.pos = (pos_now == LAST_SLOT) ? 7'h00 : pos_now + 7'h01;
					end
					state_next.push_valid = own; // R15
					state_next.push_word = {slot, byte_done};
					if ((mode == MODE_SLAVE_SIG || mode == MODE_MUX) && slot == SIG_SLOT
						&& !state_reg.cfg[CFG_CCS] && !state_reg.cfg[CFG_SIGNALING_SOURCE_SEL]) begin
						state_next.push_word = {slot, sig_done}; // R10
					end
				end
			end
		end

		// Shared pin drives a pulse on the first bit of every basic frame.
		state_next.fs_oe = (mode == MODE_SLAVE_FS) || (mode == MODE_MASTER); // R8 R12
		if (!state_next.fs_oe) begin
			state_next.fs_out = 1'b0;
		end else if (pe_evt && (!state_reg.cfg[CFG_CMS] || state_reg.phase == state_reg.cfg[CFG_EDGE_OFFSET_SEL])) begin
			state_next.fs_out = state_reg.aligned && state_reg.pos == 7'h00 && state_reg.bit_cnt == 3'h0; // R8 R12 R14
		end

		// Clock A, and clock B in master mode, only feed the jitter attenuator.
		state_next.ref_a = pin_level[PIN_CLKA]; // R11
		state_next.ref_b = (mode == MODE_MASTER) && pin_level[PIN_CLKB]; // R11

		// Output stage keeps the stream ports on flip-flops.
		if (fifo_pop) begin
			state_next.out_valid = 1'b1;
			state_next.out_word = fifo_out_data;
		end else if (slot_ready) begin
			state_next.out_valid = 1'b0;
		end

		// Register port. A drop in the same cycle as a clear keeps the flag set.
		status = '0;
		status[STAT_MODE_LSB +: 3] = mode_code(mode);
		status[STAT_ALIGNED] = state_reg.aligned;
		status[STAT_OVERRUN] = state_reg.overrun;
		status[STAT_LEVEL_LSB +: 8] = 8'(fifo_level);
		if (reg_wr && reg_addr == REG_CFG_ADDR) begin
			state_next.cfg = reg_wdata;
		end
		if (reg_wr && reg_addr == REG_OFFSET_ADDR) begin
			state_next.slot_offset = reg_wdata[6:0];
		end
		if (reg_wr && reg_addr == REG_STATUS_ADDR && reg_wdata[STAT_OVERRUN]) begin
			state_next.overrun = 1'b0;
		end
		if (state_reg.push_valid && !fifo_in_ready) begin
			state_next.overrun = 1'b1;
		end
		state_next.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CFG_ADDR: state_next.rdata = state_reg.cfg;
				REG_OFFSET_ADDR: state_next.rdata = {9'h000, state_reg.slot_offset};
				REG_STATUS_ADDR: state_next.rdata = status;
				default: state_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= '0;
			state_reg.cfg <= CFG_RESET;
			state_reg.slot_offset <= OFFSET_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign framer_frame_pulse_out = state_reg.fs_out;
	assign framer_frame_pulse_oe = state_reg.fs_oe;
	assign dpll_ref_a = state_reg.ref_a;
	assign dpll_ref_b = state_reg.ref_b;
	assign slot_valid = state_reg.out_valid;
	assign slot_number = state_reg.out_word[WORD_W-1 -: SLOT_W];
	assign slot_byte = state_reg.out_word[BYTE_W-1:0];

endmodule
`default_nettype wire

/* e1_tx_port_pkg.sv */
// Summary of operation
// R1: Mode comes from rate field, slave bit and external signaling enable bit.
// R2: Backplane clock runs at bit rate or twice; offset bit picks active edge.
// R3: Common frame pulse marks frame or multiframe; invert bit sets its polarity.
// R4: Framing-output slave mode times frame pulse, data and pulse output from clock B.
// R5: Differing frame and data edges mean frame edge precedes data edge by one.
// R6: Software programs the frame edge bit alike in all eight framers.
// R7: Bit 1 of each time slot arrives first and is transmitted first.
// R8: Framing-output slave mode drives the shared pin with a frame start pulse.
// R9: External signaling mode samples shared pin with data on the data edge.
// R10: Slot 16 takes external signaling only without common channel and source zero.
// R11: Master mode uses common clocks A and B only as jitter attenuator references.
// R12: Master mode drives the shared pin with a frame start pulse.
// R13: Master mode serial data runs at one bit per processed line clock.
// R14: Master mode times data and pulse output from the processed line clock.
// R15: Multiplexed mode takes data from one of two buses by bus select bit.
// R16: Multiplexed mode extracts own bytes at the seven bit slot offset.
// R17: Software gives each framer on one bus a distinct slot offset.
// R18: Multiplexed mode times frame pulse, data and signaling from mux clock B.
package e1_tx_port_pkg;

	// ----------
	// Register map
	// ----------
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 16;
	localparam logic [3:0] REG_CFG_ADDR = 4'h0;
	localparam logic [3:0] REG_OFFSET_ADDR = 4'h1;
	localparam logic [3:0] REG_STATUS_ADDR = 4'h2;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [6:0] OFFSET_RESET = 7'h00;

	// Configuration fields.
	localparam int CFG_RATE_LSB = 0;
	localparam int CFG_SLAVE = 2;
	localparam int CFG_SIG_EN = 3;
	localparam int CFG_CMS = 4;
	localparam int CFG_EDGE_OFFSET_SEL = 5;
	localparam int CFG_FRAME_PULSE_TYPE = 6;
	localparam int CFG_FRAME_PULSE_INVERT = 7;
	localparam int CFG_FE = 8;
	localparam int CFG_DE = 9;
	localparam int CFG_PE = 10;
	localparam int CFG_BUS_SEL = 11;
	localparam int CFG_CCS = 12;
	localparam int CFG_SIGNALING_SOURCE_SEL = 13;

	// Status fields.
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_ALIGNED = 3;
	localparam int STAT_OVERRUN = 4;
	localparam int STAT_LEVEL_LSB = 8;

	localparam logic [1:0] RATE_E1 = 2'h1;
	localparam logic [1:0] RATE_MUX = 2'h3;

	localparam logic [2:0] MODE_CODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_CODE_SLAVE_FS = 3'h1;
	localparam logic [2:0] MODE_CODE_SLAVE_SIG = 3'h2;
	localparam logic [2:0] MODE_CODE_MASTER = 3'h3;
	localparam logic [2:0] MODE_CODE_MUX = 3'h4;

	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_SLAVE_FS,
		MODE_SLAVE_SIG,
		MODE_MASTER,
		MODE_MUX
	} mode_type;

	// ----------
	// Frame layout
	// ----------
	localparam int SLOT_W = 5;
	localparam int BYTE_W = 8;
	localparam int WORD_W = 13;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [6:0] LAST_SLOT = 7'h1F;
	localparam logic [6:0] LAST_MUX_BYTE = 7'h7F;
	localparam logic [4:0] SIG_SLOT = 5'h10;
	localparam int FIFO_DEPTH_DEFAULT = 4;

	// ----------
	// Synchronised pin vector
	// ----------
	localparam int PIN_CLKB = 0;
	localparam int PIN_LTCK = 1;
	localparam int PIN_MCLKB = 2;
	localparam int PIN_CLKA = 3;
	localparam int PIN_CFS = 4;
	localparam int PIN_SD = 5;
	localparam int PIN_SIG = 6;
	localparam int PIN_MFS = 7;
	localparam int PIN_MSD0 = 8;
	localparam int PIN_MSD1 = 9;
	localparam int PIN_MSIG0 = 10;
	localparam int PIN_MSIG1 = 11;
	localparam int PIN_COUNT = 12;

endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous pins
	input wire logic [WIDTH-1:0] pin_in,
	// Synchronised level and edges
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] prev;
	} sync_state_type;

	sync_state_type state_reg;
	sync_state_type state_next;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pin_sync needs at least one pin.");
		end
	endgenerate

	// Only the second stage reads the metastable first stage.
	always_comb begin
		state_next = state_reg;
		state_next.meta = pin_in;
		state_next.stable = state_reg.meta;
		state_next.prev = state_reg.stable;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign level = state_reg.stable;
	assign rise = state_reg.stable & ~state_reg.prev;
	assign fall = ~state_reg.stable & state_reg.prev;

endmodule
`default_nettype wire

/* slot_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module slot_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] FULL_COUNT = PTR_W'(0) + (PTR_W+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W:0] count;
	} fifo_state_type;

	fifo_state_type state_reg;
	fifo_state_type state_next;
	logic push;
	logic pop;

	generate
		if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad_depth
			$error("slot_fifo needs a power-of-two depth of two or more.");
		end
	endgenerate

	assign in_ready = state_reg.count != FULL_COUNT;
	assign out_valid = state_reg.count != '0;
	assign out_data = state_reg.mem[state_reg.rd_ptr];
	assign level = state_reg.count;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointers wrap naturally because the depth is a power of two.
	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.mem[state_reg.wr_ptr] = in_data;
			state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			state_next.count = state_reg.count + 1'b1;
		end else if (pop && !push) begin
			state_next.count = state_reg.count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule
`default_nettype wire

/* e1_tx_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module e1_tx_port_properties
	import e1_tx_port_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [REG_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [REG_DATA_W-1:0] reg_rdata,
	// Pins and slot stream
	input wire logic framer_frame_pulse_out,
	input wire logic framer_frame_pulse_oe,
	input wire logic dpll_ref_b,
	input wire logic slot_valid,
	input wire logic slot_ready,
	input wire logic [SLOT_W-1:0] slot_number,
	input wire logic [BYTE_W-1:0] slot_byte
);
	// Shadow copies let the mode be judged from what software wrote, not from the design.
	logic [15:0] cfg_reg;
	logic [6:0] offset_reg;
	logic [2:0] mode_code;
	logic drive_mode;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= CFG_RESET;
			offset_reg <= OFFSET_RESET;
		end else if (reg_wr && reg_addr == REG_CFG_ADDR) begin
			cfg_reg <= reg_wdata & 16'h3FFF;
		end else if (reg_wr && reg_addr == REG_OFFSET_ADDR) begin
			offset_reg <= reg_wdata[6:0];
		end
	end
	always_comb begin
		mode_code = MODE_CODE_IDLE;
		if (cfg_reg[1:0] == RATE_E1 && !cfg_reg[CFG_SLAVE]) begin
			mode_code = MODE_CODE_MASTER;
		end else if (cfg_reg[1:0] == RATE_E1) begin
			mode_code = cfg_reg[CFG_SIG_EN] ? MODE_CODE_SLAVE_SIG : MODE_CODE_SLAVE_FS;
		end else if (cfg_reg[1:0] == RATE_MUX && cfg_reg[CFG_SLAVE] && cfg_reg[CFG_SIG_EN]) begin
			mode_code = MODE_CODE_MUX;
		end
	end
	assign drive_mode = mode_code == MODE_CODE_SLAVE_FS || mode_code == MODE_CODE_MASTER;
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence quiet_s;
		(!reg_wr) [*4];
	endsequence
	sequence status_read_s;
		reg_rd && reg_addr == REG_STATUS_ADDR;
	endsequence
	a_mode_status: assert property (quiet_s ##0 status_read_s |=> reg_rdata[2:0] == $past(mode_code))
		else $error("mode status wrong");
	a_pin_drive: assert property (drive_mode [*4] |-> framer_frame_pulse_oe)
		else $error("shared pin not driven");
	a_pin_release: assert property ((!drive_mode) [*4] |-> !framer_frame_pulse_oe)
		else $error("shared pin driven as input");
	a_pulse_width: assert property (disable iff (!rst_n || !drive_mode)
		$rose(framer_frame_pulse_out) |=> framer_frame_pulse_out [*8] ##[1:30] !framer_frame_pulse_out)
		else $error("frame pulse not one bit long");
	a_ref_b_idle: assert property ((mode_code != MODE_CODE_MASTER) [*4] |-> !dpll_ref_b)
		else $error("ref b outside master mode");
	a_cfg_readback: assert property (reg_rd && reg_addr == REG_CFG_ADDR
		|=> (reg_rdata & 16'h3FFF) == $past(cfg_reg))
		else $error("configuration readback wrong");
	a_offset_readback: assert property (reg_rd && reg_addr == REG_OFFSET_ADDR
		|=> reg_rdata[6:0] == $past(offset_reg))
		else $error("offset readback wrong");
	a_unmapped_zero: assert property (reg_rd && reg_addr > REG_STATUS_ADDR |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its cycle");
	a_hold_valid: assert property (slot_valid && !slot_ready
		|=> slot_valid && $stable(slot_number) && $stable(slot_byte))
		else $error("slot word not held");
endmodule
`default_nettype wire

/* backplane_model.sv */
`timescale 1ns/1ps
`default_nettype none
module backplane_model #(
	parameter int HALF_NS = 80
) (
	// Backplane pins
	output var logic link_clk,
	output var logic frame_pulse,
	output var logic serial_data,
	output var logic sig_data
);
	// Each byte holds 3'h3 over its slot number, so a misplaced byte shows at once.
	logic [4:0] slot = 5'h00;
	logic [2:0] bit_num = 3'h0;
	logic [7:0] pattern;
	initial begin
		link_clk = 1'b0;
		frame_pulse = 1'b0;
		serial_data = 1'b0;
		sig_data = 1'b1;
		forever begin
			#HALF_NS;
			link_clk = 1'b1;
			#HALF_NS;
			link_clk = 1'b0;
			// Values change on the falling edge, half a bit clear of the rising sample.
			pattern = {3'h3, slot};
			frame_pulse = slot == 5'h00 && bit_num == 3'h0;
			serial_data = pattern[3'h7 - bit_num];
			sig_data = ~pattern[3'h7 - bit_num];
			bit_num = bit_num + 3'h1;
			if (bit_num == 3'h0) begin
				slot = slot + 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* test_e1_tx_system_backplane_port.sv */
`timescale 1ns/1ps
`default_nettype none
module test_e1_tx_system_backplane_port
	import e1_tx_port_pkg::*;
;
	logic core_clk, rst_n, reg_wr, reg_rd, slot_ready, slot_valid;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic link_clk, fp, sd, sig, pulse_out, pulse_oe, ref_a, ref_b;
	logic [4:0] slot_number;
	logic [7:0] slot_byte;
	int err_count = 0, check_count = 0;
	backplane_model backplane_model_i (.link_clk(link_clk), .frame_pulse(fp), .serial_data(sd),
		.sig_data(sig));
	e1_tx_system_backplane_port e1_tx_system_backplane_port_i (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .common_tx_clock_a(link_clk),
		.common_tx_clock_b(link_clk), .common_tx_frame_pulse(fp), .framer_tx_serial_in(sd),
		.framer_signaling_in(sig), .framer_frame_pulse_out(pulse_out),
		.framer_frame_pulse_oe(pulse_oe), .line_processed_clock(link_clk),
		.mux_common_clock_b(link_clk), .mux_frame_pulse(fp), .mux_serial_in({sd, sd}),
		.mux_signaling_in({sig, sig}), .dpll_ref_a(ref_a), .dpll_ref_b(ref_b),
		.slot_valid(slot_valid), .slot_ready(slot_ready), .slot_number(slot_number),
		.slot_byte(slot_byte));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ----------
	// Shared tasks
	// ----------
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		check_count++;
		if (seen !== want) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
	task automatic wait_status(input int pos);
		logic [15:0] d = '0;
		for (int i = 0; i < 3000 && d[pos] !== 1'b1; i++) rd(REG_STATUS_ADDR, d);
		check(16'(d[pos]), 16'h1);
	endtask
	task automatic see_pulse();
		for (int i = 0; i < 6000 && pulse_out !== 1'b1; i++) @(negedge core_clk);
		check(16'(pulse_out), 16'h1);
		check(16'(pulse_oe), 16'h1);
	endtask
	// The first words may predate a mode change, so they are skipped.
	task automatic collect(input logic swap16);
		logic [4:0] n, nxt;
		logic [7:0] b, want;
		nxt = '0;
		for (int i = 0; i < 40; i++) begin
			@(negedge core_clk);
			for (int k = 0; k < 400 && slot_valid !== 1'b1; k++) @(negedge core_clk);
			n = slot_number;
			b = slot_byte;
			@(posedge core_clk);
			want = {3'h3, n} ^ ((swap16 && n == SIG_SLOT) ? 8'hFF : 8'h00);
			if (i >= 6) begin
				check(16'(b), 16'(want));
				check(16'(n), 16'(nxt));
			end
			nxt = n + 5'h01;
		end
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_regs();
		logic [15:0] d;
		rd(REG_CFG_ADDR, d);
		check(d, CFG_RESET);
		rd(4'hF, d);
		check(d, 16'h0000);
		wr(4'hF, 16'hFFFF);
		rd(REG_CFG_ADDR, d);
		check(d, CFG_RESET);
		wr(REG_OFFSET_ADDR, 16'h0055);
		rd(REG_OFFSET_ADDR, d);
		check(d, 16'h0055);
		$display("test regs done");
	endtask
	task automatic t_modes();
		logic [15:0] cfg [5] = '{16'h0002, 16'h0705, 16'h070D, 16'h0701, 16'h070F};
		logic [2:0] code [5] = '{MODE_CODE_IDLE, MODE_CODE_SLAVE_FS, MODE_CODE_SLAVE_SIG,
			MODE_CODE_MASTER, MODE_CODE_MUX};
		logic [15:0] d;
		for (int i = 0; i < 5; i++) begin
			wr(REG_CFG_ADDR, cfg[i]);
			repeat (4) @(posedge core_clk);
			rd(REG_STATUS_ADDR, d);
			check(16'(d[2:0]), 16'(code[i]));
		end
		$display("test modes done");
	endtask
	task automatic t_slave_fs();
		wr(REG_CFG_ADDR, 16'h0000);
		wr(REG_CFG_ADDR, 16'h0705);
		wait_status(STAT_ALIGNED);
		see_pulse();
		collect(1'b0);
		$display("test slave framing done");
	endtask
	task automatic t_slave_sig();
		wr(REG_CFG_ADDR, 16'h070D);
		wait_status(STAT_ALIGNED);
		collect(1'b1);
		wr(REG_CFG_ADDR, 16'h170D);
		collect(1'b0);
		wr(REG_CFG_ADDR, 16'h270D);
		collect(1'b0);
		$display("test slave signaling done");
	endtask
	task automatic t_overrun();
		logic [15:0] d;
		slot_ready <= 1'b0;
		wait_status(STAT_OVERRUN);
		rd(REG_STATUS_ADDR, d);
		check(16'(d[15:8]), 16'(FIFO_DEPTH_DEFAULT));
		wr(REG_CFG_ADDR, 16'h0000);
		slot_ready <= 1'b1;
		repeat (40) @(posedge core_clk);
		wr(REG_STATUS_ADDR, 16'h0010);
		rd(REG_STATUS_ADDR, d);
		check(16'(d[15:8]), 16'h0000);
		check(16'(d[STAT_OVERRUN]), 16'h0000);
		$display("test overrun done");
	endtask
	task automatic t_master();
		int ones = 0, same = 0;
		wr(REG_CFG_ADDR, 16'h0701);
		see_pulse();
		for (int i = 0; i < 400; i++) begin
			@(negedge core_clk);
			ones += int'(ref_b === 1'b1);
			same += int'(ref_a === ref_b);
		end
		check(16'(ones != 0 && ones != 400), 16'h1);
		check(16'(same), 16'h0190);
		$display("test master done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		slot_ready = 1'b1;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_regs();
		t_modes();
		t_slave_fs();
		t_slave_sig();
		t_overrun();
		t_master();
		report_and_stop();
	end
	// The tests need about 42000 cycles; a hang ends here as a failure.
	initial begin
		repeat (80000) @(posedge core_clk);
		err_count++;
		report_and_stop();
	end
endmodule
bind e1_tx_system_backplane_port e1_tx_port_properties e1_tx_port_properties_i (
	.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.framer_frame_pulse_out(framer_frame_pulse_out),
	.framer_frame_pulse_oe(framer_frame_pulse_oe), .dpll_ref_b(dpll_ref_b),
	.slot_valid(slot_valid), .slot_ready(slot_ready), .slot_number(slot_number),
	.slot_byte(slot_byte));
`default_nettype wire
